// file: flpf_defs.svh
// constants of the flash prefetch read port
`ifndef FLPF_DEFS_SVH
`define FLPF_DEFS_SVH
`define FLPF_BUS_W      64
`define FLPF_LINE_W     128
`define FLPF_ENTRIES    4
`define FLPF_ADDR_W     20
`define FLPF_TAG_W      16
`define FLPF_TAG_LSB    4
`define FLPF_HALF_BIT   3
`define FLPF_SIZE_BYTES 20'hC0000
`define FLPF_ARR_LAT    2'h2
`define FLPF_MISS_WAIT  3
`define FLPF_IDX_W      2
`define FLPF_AGE_OLDEST 2'h3
`define FLPF_MASTER_W   2
`endif

// file: flpf_pkg.sv
// types shared by the flash prefetch read port
`default_nettype none
package flpf_pkg;
  // controller states
  typedef enum logic [1:0] {FLPF_IDLE, FLPF_ISSUE, FLPF_WAIT} flpfState_t;

  // one bus read request from the crossbar_switch
  typedef struct packed {
    logic [19:0] addr;      // byte address inside the nonvolatile_array
    logic [1:0]  masterId;  // 0 instruction port, 1 data port, 2 dma
    logic        isInstr;   // instruction fetch when high
  } flpfBusReq_t;

  // static prefetch configuration
  typedef struct packed {
    logic       pfEnable;    // prefetching allowed at all
    logic       autoMode;    // prefetch on every qualifying access, else on misses only
    logic       masterOnly;  // restrict triggering to masterSel
    logic [1:0] masterSel;
    logic       instrEn;     // instruction fetches may trigger
    logic       dataEn;      // data reads may trigger
  } flpfCfg_t;
endpackage : flpf_pkg
`default_nettype wire

// file: flpf_read_port.sv
// read path between the crossbar_switch and the nonvolatile_array, with a line prefetch buffer
`timescale 1ns/1ps
`default_nettype none
`include "flpf_defs.svh"
module flpf_read_port (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         ce,
  input  wire logic                         busValid,
  input  wire flpf_pkg::flpfBusReq_t        busReq,
  output logic                              busReady,
  output logic                              busRespValid,
  output logic                              busErr,
  output logic [`FLPF_BUS_W-1:0]            busRdata,
  output logic                              arrRead,
  output logic [`FLPF_TAG_W-1:0]            arrLine,
  input  wire logic [`FLPF_LINE_W-1:0]      arrData,
  input  wire flpf_pkg::flpfCfg_t           cfg
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  flpf_pkg::flpfState_t              stateQ, stateD;
  logic [1:0]                        cntQ, cntD;
  logic [`FLPF_TAG_W-1:0]            lineQ, lineD;
  logic                              halfQ, halfD;
  logic                              isPrefQ, isPrefD;
  logic                              pendQ, pendD;
  logic [`FLPF_TAG_W-1:0]            pendLineQ, pendLineD;
  logic                              respQ, respD;
  logic                              errQ, errD;
  logic [`FLPF_BUS_W-1:0]            rdataQ, rdataD;
  logic [`FLPF_ENTRIES-1:0]          validQ, validD;
  logic [`FLPF_TAG_W-1:0]            tagQ [`FLPF_ENTRIES];
  logic [`FLPF_TAG_W-1:0]            tagD [`FLPF_ENTRIES];
  logic [1:0]                        ageQ [`FLPF_ENTRIES];
  logic [1:0]                        ageD [`FLPF_ENTRIES];
  logic [`FLPF_LINE_W-1:0]           lineBuf [`FLPF_ENTRIES];
  // ------------------------------------------------------------
  // lookup and replacement choice
  // ------------------------------------------------------------
  logic [`FLPF_TAG_W-1:0]            reqLine;
  logic                              inRange, hit, pfInBuf, take, qualify;
  logic [`FLPF_IDX_W-1:0]            hitIdx, victim, touchIdx;
  logic                              touch, fill;
  assign reqLine  = busReq.addr[`FLPF_ADDR_W-1:`FLPF_TAG_LSB];
  assign inRange  = busReq.addr < `FLPF_SIZE_BYTES;
  assign busReady = (stateQ == flpf_pkg::FLPF_IDLE);
  assign take     = busValid && busReady;
  // tag compare over all entries; victim is the first invalid, else the oldest
  always_comb begin
    hit     = 1'b0;
    hitIdx  = '0;
    pfInBuf = 1'b0;
    victim  = '0;
    for (int i = `FLPF_ENTRIES - 1; i >= 0; i--) begin
      if (validQ[i] && tagQ[i] == reqLine) begin
        hit    = 1'b1;
        hitIdx = i[`FLPF_IDX_W-1:0];
      end
      if (validQ[i] && tagQ[i] == pendLineQ) begin
        pfInBuf = 1'b1;
      end
    end
    for (int i = `FLPF_ENTRIES - 1; i >= 0; i--) begin
      if (validQ[i] && ageQ[i] == `FLPF_AGE_OLDEST && &validQ) begin
        victim = i[`FLPF_IDX_W-1:0];
      end
    end
    for (int i = `FLPF_ENTRIES - 1; i >= 0; i--) begin
      if (!validQ[i]) begin
        victim = i[`FLPF_IDX_W-1:0];
      end
    end
  end
  // prefetch trigger filter; masters and types outside the selection never start one
  always_comb begin
    qualify = cfg.pfEnable
           && (!cfg.masterOnly || busReq.masterId == cfg.masterSel)
           && (busReq.isInstr ? cfg.instrEn : cfg.dataEn)
           && (cfg.autoMode || !hit);
  end
  // ------------------------------------------------------------
  // controller next state
  // ------------------------------------------------------------
  // a prefetch in flight holds busReady low; simpler than aborting it, costs a few cycles
  always_comb begin
    stateD    = stateQ;
    cntD      = cntQ;
    lineD     = lineQ;
    halfD     = halfQ;
    isPrefD   = isPrefQ;
    pendD     = pendQ;
    pendLineD = pendLineQ;
    respD     = 1'b0;
    errD      = 1'b0;
    rdataD    = rdataQ;
    arrRead   = 1'b0;
    touch     = 1'b0;
    touchIdx  = hitIdx;
    fill      = 1'b0;
    case (stateQ)
      flpf_pkg::FLPF_IDLE: begin
        if (take) begin
          if (!inRange) begin
            respD = 1'b1;
            errD  = 1'b1;
          end else begin
            if (hit) begin
              respD  = 1'b1;
              rdataD = busReq.addr[`FLPF_HALF_BIT] ? lineBuf[hitIdx][127:64] : lineBuf[hitIdx][63:0];
              touch  = 1'b1;
            end else begin
              stateD  = flpf_pkg::FLPF_ISSUE;
              lineD   = reqLine;
              halfD   = busReq.addr[`FLPF_HALF_BIT];
              isPrefD = 1'b0;
            end
            if (qualify) begin
              pendD     = 1'b1;
              pendLineD = reqLine + 16'h0001;
            end
          end
        end else if (pendQ) begin
          pendD = 1'b0;
          // line past the top of the array or already held: nothing to fetch
          if (!pfInBuf && {pendLineQ, 4'h0} < `FLPF_SIZE_BYTES) begin
            stateD  = flpf_pkg::FLPF_ISSUE;
            lineD   = pendLineQ;
            isPrefD = 1'b1;
          end
        end
      end
      flpf_pkg::FLPF_ISSUE: begin
        arrRead = 1'b1;
        cntD    = 2'h0;
        stateD  = flpf_pkg::FLPF_WAIT;
      end
      flpf_pkg::FLPF_WAIT: begin
        if (cntQ == `FLPF_ARR_LAT - 2'h1) begin
          fill     = 1'b1;
          touch    = 1'b1;
          touchIdx = victim;
          stateD   = flpf_pkg::FLPF_IDLE;
          if (!isPrefQ) begin
            respD  = 1'b1;
            rdataD = halfQ ? arrData[127:64] : arrData[63:0];
          end
        end else begin
          cntD = cntQ + 2'h1;
        end
      end
      default: begin
        stateD = flpf_pkg::FLPF_IDLE;
      end
    endcase
  end
  // buffer tags, valid bits and recency ages
  always_comb begin
    validD = validQ;
    for (int i = 0; i < `FLPF_ENTRIES; i++) begin
      tagD[i] = tagQ[i];
      ageD[i] = ageQ[i];
      if (touch) begin
        if (i[`FLPF_IDX_W-1:0] == touchIdx) begin
          ageD[i] = 2'h0;
        end else if (ageQ[i] < ageQ[touchIdx]) begin
          ageD[i] = ageQ[i] + 2'h1;
        end
      end
    end
    if (fill) begin
      validD[victim] = 1'b1;
      tagD[victim]   = lineQ;
    end
  end
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // ages start as a permutation so the oldest entry is always unique
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateQ    <= flpf_pkg::FLPF_IDLE;
      cntQ      <= 2'h0;
      lineQ     <= 16'h0000;
      halfQ     <= 1'b0;
      isPrefQ   <= 1'b0;
      pendQ     <= 1'b0;
      pendLineQ <= 16'h0000;
      respQ     <= 1'b0;
      errQ      <= 1'b0;
      rdataQ    <= 64'h0;
      validQ    <= 4'h0;
      for (int i = 0; i < `FLPF_ENTRIES; i++) begin
        tagQ[i] <= 16'h0000;
        ageQ[i] <= i[1:0];
      end
    end else if (ce) begin
      stateQ    <= stateD;
      cntQ      <= cntD;
      lineQ     <= lineD;
      halfQ     <= halfD;
      isPrefQ   <= isPrefD;
      pendQ     <= pendD;
      pendLineQ <= pendLineD;
      respQ     <= respD;
      errQ      <= errD;
      rdataQ    <= rdataD;
      validQ    <= validD;
      for (int i = 0; i < `FLPF_ENTRIES; i++) begin
        tagQ[i] <= tagD[i];
        ageQ[i] <= ageD[i];
      end
    end
  end

  // line storage has no reset; the valid bits guard it
  always_ff @(posedge clk) begin
    if (ce && fill) begin
      lineBuf[victim] <= arrData;
    end
  end
  assign busRespValid = respQ;
  assign busErr       = errQ;
  assign busRdata     = rdataQ;
  assign arrLine      = lineQ;
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_missTaken;
    take && inRange && !hit;
  endsequence
  sequence s_missAnswer;
    !busRespValid [*3] ##1 busRespValid && !busErr;
  endsequence
  property p_hitZeroWait;
    @(posedge clk) disable iff (!rst_n || !ce) take && inRange && hit |=> busRespValid && !busErr;
  endproperty
  a_hitZeroWait: assert property (p_hitZeroWait) else $error("hit not answered next cycle");
  property p_missThreeWait;
    @(posedge clk) disable iff (!rst_n || !ce) s_missTaken |=> s_missAnswer;
  endproperty
  a_missThreeWait: assert property (p_missThreeWait) else $error("miss not answered after three waits");
  property p_missData;
    @(posedge clk) disable iff (!rst_n || !ce)
      stateQ == flpf_pkg::FLPF_WAIT && stateD == flpf_pkg::FLPF_IDLE && !isPrefQ
      |=> busRdata == (halfQ ? $past(arrData[127:64]) : $past(arrData[63:0]));
  endproperty
  a_missData: assert property (p_missData) else $error("miss data not the addressed half");
  property p_rangeErr;
    @(posedge clk) disable iff (!rst_n || !ce) take && !inRange |=> busRespValid && busErr;
  endproperty
  a_rangeErr: assert property (p_rangeErr) else $error("out of range read not flagged");
  property p_masterFilter;
    @(posedge clk) disable iff (!rst_n || !ce)
      take && !pendQ && cfg.masterOnly && busReq.masterId != cfg.masterSel |=> !pendQ;
  endproperty
  a_masterFilter: assert property (p_masterFilter) else $error("foreign master started a prefetch");
  property p_typeFilter;
    @(posedge clk) disable iff (!rst_n || !ce)
      take && !pendQ && (busReq.isInstr ? !cfg.instrEn : !cfg.dataEn) |=> !pendQ;
  endproperty
  a_typeFilter: assert property (p_typeFilter) else $error("filtered access type started a prefetch");
  property p_prefetchIssue;
    @(posedge clk) disable iff (!rst_n || !ce)
      take && inRange && hit && qualify |=> pendQ && pendLineQ == $past(reqLine) + 16'h0001;
  endproperty
  a_prefetchIssue: assert property (p_prefetchIssue) else $error("next line not queued for prefetch");
  property p_autoOff;
    @(posedge clk) disable iff (!rst_n || !ce) take && !pendQ && hit && !cfg.autoMode |=> !pendQ;
  endproperty
  a_autoOff: assert property (p_autoOff) else $error("hit prefetched outside auto mode");
  property p_lruVictim;
    @(posedge clk) disable iff (!rst_n || !ce) fill && &validQ |-> ageQ[victim] == `FLPF_AGE_OLDEST;
  endproperty
  a_lruVictim: assert property (p_lruVictim) else $error("replaced entry is not the oldest");
  property p_fillTag;
    @(posedge clk) disable iff (!rst_n || !ce) fill |=> validQ[$past(victim)] && tagQ[$past(victim)] == $past(lineQ);
  endproperty
  a_fillTag: assert property (p_fillTag) else $error("filled entry not valid with its line");
endmodule : flpf_read_port
`default_nettype wire

// file: flpf_array_model.sv
// behavioural model of the nonvolatile_array line read interface
`timescale 1ns/1ps
`default_nettype none
module flpf_array_model (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         arrRead,
  input  wire logic [15:0]  arrLine,
  output logic      [127:0] arrData,
  output logic      [7:0]   readCount
);
  logic        pend1_q;
  logic        pend2_q;
  logic        junk_q;
  logic [15:0] line1_q;
  logic [15:0] line2_q;
  // ----------------------------------------
  // contents
  // ----------------------------------------
  // words derive from the line address, halves differ, so a wrong line or half shows
  function automatic logic [127:0] lineOf(input logic [15:0] l);
    return {l, 16'h0001, ~l, 16'h0002, l, 16'h0003, ~l, 16'h0004};
  endfunction : lineOf
  // two-stage read pipeline, one 128-bit line per read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend1_q   <= 1'h0;
      pend2_q   <= 1'h0;
      junk_q    <= 1'h0;
      line1_q   <= 16'h0000;
      line2_q   <= 16'h0000;
      readCount <= 8'h00;
    end else begin
      pend1_q <= arrRead;
      pend2_q <= pend1_q;
      line1_q <= arrLine;
      line2_q <= line1_q;
      junk_q  <= ~junk_q;
      if (arrRead) begin
        readCount <= readCount + 8'h01;
      end
    end
  end
  // valid only two cycles after the request; churns otherwise so early samples fail
  assign arrData = pend2_q ? lineOf(line2_q) : {64{junk_q, ~junk_q}};
endmodule : flpf_array_model
`default_nettype wire

// file: flpf_read_port_tb_top.sv
// self-checking testbench of the flash prefetch read port
`timescale 1ns/1ps
`default_nettype none
module flpf_read_port_tb_top;
  logic                  clk;
  logic                  rst_n;
  logic                  ce;
  logic                  busValid;
  flpf_pkg::flpfBusReq_t busReq;
  flpf_pkg::flpfCfg_t    cfg;
  logic                  busReady;
  logic                  busRespValid;
  logic                  busErr;
  logic [63:0]           busRdata;
  logic                  arrRead;
  logic [15:0]           arrLine;
  logic [127:0]          arrData;
  logic [7:0]            readCount;
  int                    failures;
  int                    compares;
  int                    cycles;
  // ----------------------------------------
  // design and array model
  // ----------------------------------------
  flpf_read_port u_flpf_read_port (.clk(clk), .rst_n(rst_n), .ce(ce), .busValid(busValid),
    .busReq(busReq), .busReady(busReady), .busRespValid(busRespValid), .busErr(busErr),
    .busRdata(busRdata), .arrRead(arrRead), .arrLine(arrLine), .arrData(arrData), .cfg(cfg));
  flpf_array_model u_flpf_array_model (.clk(clk), .rst_n(rst_n), .arrRead(arrRead),
    .arrLine(arrLine), .arrData(arrData), .readCount(readCount));
  // 250 MHz clock
  initial clk = 1'h0;
  always #2 clk = ~clk;
  // hang guard, far above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      final_report();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic final_report;
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  task automatic chkVal(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (e !== g) begin
      failures++;
      $display("unexpected %s expected %0h seen %0h", n, e, g);
    end
  endtask : chkVal
  task automatic chkData(input string n, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (e !== g) begin
      failures++;
      $display("unexpected %s expected %0h seen %0h", n, e, g);
    end
  endtask : chkData
  // reset held three cycles, released at a falling edge
  task automatic resetDut;
    rst_n = 1'h0;
    busValid = 1'h0;
    repeat (3) @(negedge clk);
    rst_n = 1'h1;
  endtask : resetDut
  task automatic setCfg(input logic pe, am, mo, input logic [1:0] ms, input logic ie, de);
    cfg = {pe, am, mo, ms, ie, de};
  endtask : setCfg
  // lets a queued prefetch run to completion before the next request
  task automatic settle;
    repeat (8) @(negedge clk);
  endtask : settle
  // one bus read; wait states counted from the take edge to the answer
  task automatic rd(input logic [19:0] a, input logic [1:0] m, input logic [7:0] expWs, input logic expErr);
    logic [15:0]  l;
    logic [127:0] ln;
    int           n;
    l = a[19:4];
    ln = {l, 16'h0001, ~l, 16'h0002, l, 16'h0003, ~l, 16'h0004};
    busReq.addr = a;
    busReq.masterId = m;
    busReq.isInstr = (m == 2'h0);
    busValid = 1'h1;
    n = 0;
    while (busReady !== 1'h1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    busValid = 1'h0;
    n = 0;
    while (busRespValid !== 1'h1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chkVal("wait states", expWs, n[7:0]);
    chkVal("error flag", {7'h00, expErr}, {7'h00, busErr});
    if (!expErr) chkData("read data", a[3] ? ln[127:64] : ln[63:0], busRdata);
    @(negedge clk);
  endtask : rd
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_resetValues;
    resetDut();
    chkVal("ready after reset", 8'h01, {7'h00, busReady});
    chkVal("answer after reset", 8'h00, {7'h00, busRespValid});
    chkData("data after reset", 64'h0, busRdata);
  endtask : s_resetValues
  task automatic s_missHit;
    logic [7:0] c;
    resetDut();
    setCfg(1'h0, 1'h0, 1'h0, 2'h0, 1'h1, 1'h1);
    c = readCount;
    rd(20'h00100, 2'h1, 8'h03, 1'h0);
    rd(20'h00108, 2'h1, 8'h00, 1'h0);
    rd(20'h00100, 2'h2, 8'h00, 1'h0);
    settle();
    chkVal("array reads", c + 8'h01, readCount);
  endtask : s_missHit
  task automatic s_lru;
    resetDut();
    setCfg(1'h0, 1'h0, 1'h0, 2'h0, 1'h1, 1'h1);
    for (int i = 1; i <= 4; i++) rd(20'(i * 16), 2'h1, 8'h03, 1'h0);
    rd(20'h00010, 2'h1, 8'h00, 1'h0);
    rd(20'h00050, 2'h1, 8'h03, 1'h0);
    rd(20'h00018, 2'h1, 8'h00, 1'h0);
    rd(20'h00030, 2'h1, 8'h00, 1'h0);
    rd(20'h00040, 2'h1, 8'h00, 1'h0);
    rd(20'h00020, 2'h1, 8'h03, 1'h0);
  endtask : s_lru
  task automatic s_autoMode;
    resetDut();
    setCfg(1'h1, 1'h0, 1'h0, 2'h0, 1'h1, 1'h1);
    rd(20'h00200, 2'h1, 8'h03, 1'h0);
    settle();
    rd(20'h00218, 2'h1, 8'h00, 1'h0);
    settle();
    rd(20'h00220, 2'h1, 8'h03, 1'h0);
    setCfg(1'h1, 1'h1, 1'h0, 2'h0, 1'h1, 1'h1);
    rd(20'h00300, 2'h1, 8'h03, 1'h0);
    settle();
    rd(20'h00310, 2'h1, 8'h00, 1'h0);
    settle();
    rd(20'h00320, 2'h1, 8'h00, 1'h0);
  endtask : s_autoMode
  task automatic s_masterOnly;
    logic [7:0] c;
    resetDut();
    setCfg(1'h1, 1'h1, 1'h1, 2'h2, 1'h1, 1'h1);
    for (int m = 0; m < 3; m++) begin
      c = readCount;
      rd(20'h01000 + 20'(m * 256), 2'(m), 8'h03, 1'h0);
      settle();
      chkVal("array reads", c + ((m == 2) ? 8'h02 : 8'h01), readCount);
    end
  endtask : s_masterOnly
  task automatic s_accessType;
    logic [7:0] c;
    resetDut();
    for (int k = 0; k < 4; k++) begin
      setCfg(1'h1, 1'h1, 1'h0, 2'h0, k[0], k[1]);
      for (int m = 0; m < 2; m++) begin
        c = readCount;
        rd(20'h02000 + 20'(k * 256 + m * 32), 2'(m), 8'h03, 1'h0);
        settle();
        chkVal("array reads", c + 8'h01 + ((m == 0) ? 8'(k[0]) : 8'(k[1])), readCount);
      end
    end
  endtask : s_accessType
  task automatic s_range;
    logic [7:0] c;
    resetDut();
    setCfg(1'h1, 1'h1, 1'h0, 2'h0, 1'h1, 1'h1);
    c = readCount;
    rd(20'hC0000, 2'h1, 8'h00, 1'h1);
    rd(20'hFFFF8, 2'h2, 8'h00, 1'h1);
    rd(20'hBFFF8, 2'h1, 8'h03, 1'h0);
    settle();
    chkVal("array reads", c + 8'h01, readCount);
  endtask : s_range
  // a frozen block must neither take the waiting request nor answer it
  task automatic s_clockEnable;
    resetDut();
    setCfg(1'h0, 1'h0, 1'h0, 2'h0, 1'h1, 1'h1);
    rd(20'h00400, 2'h1, 8'h03, 1'h0);
    ce = 1'h0;
    busReq.addr = 20'h00408;
    busValid = 1'h1;
    repeat (3) @(negedge clk);
    chkVal("answer while frozen", 8'h00, {7'h00, busRespValid});
    ce = 1'h1;
    @(negedge clk);
    busValid = 1'h0;
    chkVal("answer after thaw", 8'h01, {7'h00, busRespValid});
    chkData("data after thaw", 64'h00400001FFBF0002, busRdata);
    @(negedge clk);
  endtask : s_clockEnable
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'h0;
    busValid = 1'h0;
    busReq = '0;
    ce = 1'h1;
    cfg = '0;
    failures = 0;
    compares = 0;
    cycles = 0;
    @(negedge clk);
    s_resetValues();
    s_missHit();
    s_lru();
    s_autoMode();
    s_masterOnly();
    s_accessType();
    s_range();
    s_clockEnable();
    final_report();
  end
endmodule : flpf_read_port_tb_top
`default_nettype wire
